// File: shared/pcs_defs.svh
// register offsets, field positions and reset values for the pll control
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
`define PCS_ADDR_W 4
`define PCS_OFF_CTRL 4'h0
`define PCS_OFF_BWC 4'h4
`define PCS_OFF_PROG 4'h8
`define PCS_CTRL_IE 7
`define PCS_CTRL_FLAG 6
`define PCS_CTRL_ON 5
`define PCS_CTRL_BCS 4
`define PCS_CTRL_UNUSED 4'hF
`define PCS_BWC_AUTO 7
`define PCS_BWC_LOCK 6
`define PCS_BWC_ACQ 5
`define PCS_BWC_XLD 4
`define PCS_RST_MUL 4'h6
`define PCS_RST_VRS 4'h6
`define PCS_SWITCH_EDGES 3
`define PCS_RESP_OKAY 2'h0
`define PCS_RESP_SLVERR 2'h2
`endif

// File: shared/pcs_pkg.sv
// types shared by the pll clock select control
package pcs_pkg;
  typedef enum logic [0:0] {
    PCS_SW_IDLE = 1'b0,
    PCS_SW_WAIT = 1'b1
  } pcs_sw_e;
  typedef struct packed {
    logic vco_on;
    logic auto_bw;
    logic acq_track;
    logic [3:0] multiplier;
    logic [3:0] vco_range;
  } pcs_ana_out_s;
  typedef struct packed {
    logic aw_full;
    logic [3:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic ie;
    logic flag;
    logic vco_enable;
    logic base_source_select;
    logic auto_bw;
    logic acq_manual;
    logic crystal_loss_bit;
    logic [3:0] mul;
    logic [3:0] vrs;
    logic lock_prev;
    logic [1:0] xt_sync;
    logic [1:0] vc_sync;
    logic [1:0] lk_sync;
    logic [1:0] tr_sync;
    logic xt_prev;
    logic vc_prev;
    pcs_sw_e sw;
    logic [1:0] xcnt;
    logic [1:0] vcnt;
    logic active_sel;
    logic base_q;
    logic xclk_q;
  } pcs_state_s;
endpackage

// File: design/pcs_top.sv
// pll clock select control with axi4-lite register slave
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "pcs_defs.svh"
module pcs_top #(
  parameter int SWITCH_EDGES = `PCS_SWITCH_EDGES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [`PCS_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [`PCS_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // clocks and status from the analog pll
  input wire logic crystal_clock,
  input wire logic vco_clock,
  input wire logic pll_locked,
  input wire logic pll_tracking,
  // system controls
  input wire logic stop_mode,
  input wire logic break_state,
  input wire logic break_clear_enable,
  // outputs
  output pcs_pkg::pcs_ana_out_s ana_out,
  output logic base_clock_out,
  output logic crystal_clock_out,
  output logic pll_irq_request
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (SWITCH_EDGES < 1 || SWITCH_EDGES > 3) begin : g_chk
    $error("pcs_top: SWITCH_EDGES must be 1 to 3");
  end
  if (`PCS_ADDR_W < 4) begin : g_addr_chk
    $error("pcs_top: address width too narrow for the map");
  end

  localparam logic [1:0] SW_EDGES = 2'(SWITCH_EDGES);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pcs_pkg::pcs_state_s s;
  pcs_pkg::pcs_state_s next_s;

  logic unused_ok;
  assign unused_ok = ^{awprot, arprot, wdata[31:8], wstrb[3:1]};

  // ---------------------------------------------------------------
  // derived status
  // ---------------------------------------------------------------
  logic lock_ind;
  logic xt_rise;
  logic vc_rise;
  logic flag_vis;
  logic ie_vis;
  logic acq_vis;
  logic xld_vis;
  logic do_wr;
  logic rd_take;
  logic flag_keep;

  assign lock_ind = s.auto_bw & s.lk_sync[1];
  assign xt_rise = s.xt_sync[1] & ~s.xt_prev;
  assign vc_rise = s.vc_sync[1] & ~s.vc_prev;
  assign flag_vis = s.flag & s.auto_bw;
  assign ie_vis = s.ie & s.auto_bw;
  assign acq_vis = s.auto_bw ? s.tr_sync[1] : s.acq_manual;
  assign xld_vis = s.crystal_loss_bit & s.base_source_select;
  assign do_wr = s.aw_full & s.w_full & ~s.bvalid;
  assign rd_take = arvalid & ~s.rvalid;
  assign flag_keep = break_state & ~break_clear_enable;

  // ---------------------------------------------------------------
  // read value
  // ---------------------------------------------------------------
  function automatic logic [8:0] rd_value(
    input logic [`PCS_ADDR_W-1:0] a
  );
    logic [8:0] v;
    v = 9'h000;
    case (a)
      `PCS_OFF_CTRL: begin
        v[`PCS_CTRL_IE] = ie_vis;
        v[`PCS_CTRL_FLAG] = flag_vis;
        v[`PCS_CTRL_ON] = s.vco_enable;
        v[`PCS_CTRL_BCS] = s.base_source_select;
        v[3:0] = `PCS_CTRL_UNUSED;
      end
      `PCS_OFF_BWC: begin
        v[`PCS_BWC_AUTO] = s.auto_bw;
        v[`PCS_BWC_LOCK] = lock_ind;
        v[`PCS_BWC_ACQ] = acq_vis;
        v[`PCS_BWC_XLD] = xld_vis;
      end
      `PCS_OFF_PROG: begin
        v[7:4] = s.mul;
        v[3:0] = s.vrs;
      end
      default: begin
        v[8] = 1'b1;
      end
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [8:0] rv;
    logic [8:0] wchk;
    logic [7:0] wd;
    rv = 9'h000;
    wchk = 9'h000;
    wd = s.w_data;
    next_s = s;

    // -------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------
    next_s.xt_sync = {s.xt_sync[0], crystal_clock};
    next_s.vc_sync = {s.vc_sync[0], vco_clock};
    next_s.lk_sync = {s.lk_sync[0], pll_locked};
    next_s.tr_sync = {s.tr_sync[0], pll_tracking};
    next_s.xt_prev = s.xt_sync[1];
    next_s.vc_prev = s.vc_sync[1];

    // -------------------------------------------------------------
    // write channel capture
    // -------------------------------------------------------------
    if (awvalid && !s.aw_full) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && !s.w_full) begin
      next_s.w_full = 1'b1;
      next_s.w_data = wdata[7:0];
      next_s.w_strb0 = wstrb[0];
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end

    // -------------------------------------------------------------
    // register write
    // -------------------------------------------------------------
    if (do_wr) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      wchk = rd_value(s.aw_addr);
      next_s.bresp = wchk[8] ? `PCS_RESP_SLVERR : `PCS_RESP_OKAY;
      if (s.w_strb0) begin
        case (s.aw_addr)
          `PCS_OFF_CTRL: begin
            if (s.auto_bw) begin
              next_s.ie = wd[`PCS_CTRL_IE];
            end
            if (!(s.base_source_select && !wd[`PCS_CTRL_ON])) begin
              next_s.vco_enable = wd[`PCS_CTRL_ON];
            end
            if (!wd[`PCS_CTRL_BCS]) begin
              next_s.base_source_select = 1'b0;
            end else if (s.vco_enable && s.vrs != 4'h0) begin
              next_s.base_source_select = 1'b1;
            end
          end
          `PCS_OFF_BWC: begin
            next_s.auto_bw = wd[`PCS_BWC_AUTO];
            if (!s.auto_bw) begin
              next_s.acq_manual = wd[`PCS_BWC_ACQ];
            end
            if (wd[`PCS_BWC_XLD]) begin
              next_s.crystal_loss_bit = 1'b1;
            end
          end
          `PCS_OFF_PROG: begin
            if (!s.vco_enable) begin
              next_s.mul = wd[7:4];
              next_s.vrs = wd[3:0];
            end
          end
          default: begin
            next_s.bresp = `PCS_RESP_SLVERR;
          end
        endcase
      end
    end

    // -------------------------------------------------------------
    // zero range disables the pll and the vco selection
    // -------------------------------------------------------------
    if (next_s.vrs == 4'h0) begin
      next_s.vco_enable = 1'b0;
      next_s.base_source_select = 1'b0;
    end

    // -------------------------------------------------------------
    // stop deselects the vco
    // -------------------------------------------------------------
    if (stop_mode) begin
      next_s.base_source_select = 1'b0;
    end

    // -------------------------------------------------------------
    // crystal loss: a rising crystal edge clears, new write wins
    // -------------------------------------------------------------
    if (xt_rise && !(do_wr && s.w_strb0 && s.aw_addr == `PCS_OFF_BWC
        && wd[`PCS_BWC_XLD])) begin
      next_s.crystal_loss_bit = 1'b0;
    end
    if (!s.base_source_select) begin
      next_s.crystal_loss_bit = 1'b0;
    end

    // -------------------------------------------------------------
    // read channel
    // -------------------------------------------------------------
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_take) begin
      rv = rd_value(araddr);
      next_s.rvalid = 1'b1;
      next_s.rdata = rv[7:0];
      next_s.rresp = rv[8] ? `PCS_RESP_SLVERR : `PCS_RESP_OKAY;
      if (araddr == `PCS_OFF_CTRL && !flag_keep) begin
        next_s.flag = 1'b0;
      end
    end

    // -------------------------------------------------------------
    // lock change detection, set wins over read clear
    // -------------------------------------------------------------
    next_s.lock_prev = lock_ind;
    if (lock_ind != s.lock_prev) begin
      next_s.flag = 1'b1;
    end

    // -------------------------------------------------------------
    // base clock transition control
    // -------------------------------------------------------------
    case (s.sw)
      pcs_pkg::PCS_SW_IDLE: begin
        if (s.base_source_select != s.active_sel) begin
          next_s.sw = pcs_pkg::PCS_SW_WAIT;
          next_s.xcnt = 2'h0;
          next_s.vcnt = 2'h0;
        end else if (s.active_sel ? vc_rise : xt_rise) begin
          next_s.base_q = ~s.base_q;
        end
      end
      pcs_pkg::PCS_SW_WAIT: begin
        if (xt_rise && s.xcnt != SW_EDGES) begin
          next_s.xcnt = s.xcnt + 2'h1;
        end
        if (vc_rise && s.vcnt != SW_EDGES) begin
          next_s.vcnt = s.vcnt + 2'h1;
        end
        if (s.base_source_select == s.active_sel) begin
          next_s.sw = pcs_pkg::PCS_SW_IDLE;
        end else if (s.xcnt == SW_EDGES && s.vcnt == SW_EDGES) begin
          next_s.active_sel = s.base_source_select;
          next_s.sw = pcs_pkg::PCS_SW_IDLE;
        end
      end
      default: begin
        next_s.sw = pcs_pkg::PCS_SW_IDLE;
      end
    endcase

    // -------------------------------------------------------------
    // stop holds clock outputs low
    // -------------------------------------------------------------
    next_s.xclk_q = stop_mode ? 1'b0 : s.xt_sync[1];
    if (stop_mode) begin
      next_s.base_q = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.vco_enable <= 1'b1;
      s.mul <= `PCS_RST_MUL;
      s.vrs <= `PCS_RST_VRS;
      s.sw <= pcs_pkg::PCS_SW_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign awready = ~s.aw_full;
  assign wready = ~s.w_full;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = ~s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = {24'h000000, s.rdata};
  assign rresp = s.rresp;

  // ---------------------------------------------------------------
  // analog side controls
  // ---------------------------------------------------------------
  assign ana_out.vco_on = s.vco_enable & ~stop_mode;
  assign ana_out.auto_bw = s.auto_bw;
  assign ana_out.acq_track = s.acq_manual;
  assign ana_out.multiplier = (s.mul == 4'h0) ? 4'h1 : s.mul;
  assign ana_out.vco_range = s.vrs;

  // ---------------------------------------------------------------
  // clock and interrupt outputs
  // ---------------------------------------------------------------
  assign base_clock_out = s.base_q;
  assign crystal_clock_out = s.xclk_q;
  assign pll_irq_request = flag_vis & ie_vis & ~stop_mode;

endmodule
`default_nettype wire

// File: verif/pcs_top_chk.sv
// assertion checker for the pll clock select control
`timescale 1ns/10ps
`default_nettype none
`include "pcs_defs.svh"
module pcs_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register read
  input wire logic [`PCS_ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  // controls and outputs
  input wire logic stop_mode,
  input wire pcs_pkg::pcs_ana_out_s ana_out,
  input wire logic base_clock_out,
  input wire logic crystal_clock_out,
  input wire logic pll_irq_request
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------
  // properties
  // ----------
  ctrl_ones_a: assert property (
    $rose(rvalid) && $past(araddr) == `PCS_OFF_CTRL |-> rdata[3:0] == 4'hF)
    else $error("control low bits not ones");
  manual_ctrl_a: assert property (
    $rose(rvalid) && $past(araddr) == `PCS_OFF_CTRL &&
    $past(!ana_out.auto_bw) |-> rdata[7:6] == 2'b00)
    else $error("manual mode shows flag or enable");
  manual_lock_a: assert property (
    $rose(rvalid) && $past(araddr) == `PCS_OFF_BWC &&
    $past(!ana_out.auto_bw) |-> !rdata[6])
    else $error("manual mode shows lock");
  irq_gate_a: assert property (
    pll_irq_request |-> ana_out.auto_bw && !stop_mode)
    else $error("interrupt outside automatic run");
  stop_hold_a: assert property (
    stop_mode ##1 stop_mode |-> !crystal_clock_out && !ana_out.vco_on)
    else $error("outputs live in stop");
  mul_one_a: assert property (
    ana_out.multiplier != 4'h0)
    else $error("multiplier zero");
  range_off_a: assert property (
    ana_out.vco_range == 4'h0 |-> !ana_out.vco_on)
    else $error("zero range with vco on");
  prog_lock_a: assert property (
    ana_out.vco_on |=> $stable(ana_out.multiplier) &&
    $stable(ana_out.vco_range))
    else $error("programming changed while on");
  base_div_a: assert property (
    $changed(base_clock_out) && !stop_mode |=> $stable(base_clock_out))
    else $error("base clock not divided");
  reset_vals_a: assert property (
    $rose(aresetn) |-> ana_out.multiplier == `PCS_RST_MUL &&
    ana_out.vco_range == `PCS_RST_VRS && !ana_out.auto_bw &&
    (ana_out.vco_on || stop_mode))
    else $error("bad reset values");
  cover property ($rose(pll_irq_request));
  cover property ($changed(base_clock_out));
  cover property (stop_mode ##1 !stop_mode);
endmodule
bind pcs_top pcs_chk i_pcs_chk (.aclk, .aresetn, .araddr, .rvalid, .rdata,
  .stop_mode, .ana_out, .base_clock_out, .crystal_clock_out,
  .pll_irq_request);
`default_nettype wire

// File: verif/pcs_ana_model.sv
// behavioural model of the analog pll and crystal oscillator
`timescale 1ns/10ps
`default_nettype none
module pcs_ana_model (
  // clock and commands
  input wire logic aclk,
  input wire logic xtal_run,
  input wire logic lock_req,
  input wire pcs_pkg::pcs_ana_out_s ana_in,
  // analog side
  output logic crystal_clock,
  output logic vco_clock,
  output logic pll_locked,
  output logic pll_tracking
);
  int xc = 0;
  int vc = 0;
  initial begin
    crystal_clock = 1'b0;
    vco_clock = 1'b0;
    pll_locked = 1'b0;
    pll_tracking = 1'b0;
  end
  // crystal stands still when stopped, vco runs only while on
  always @(posedge aclk) begin
    xc <= (xc + 1) % 3;
    vc <= (vc + 1) % 2;
    if (xtal_run && xc == 2) crystal_clock <= !crystal_clock;
    if (ana_in.vco_on && vc == 1) vco_clock <= !vco_clock;
    pll_locked <= lock_req && ana_in.vco_on;
    pll_tracking <= lock_req && ana_in.vco_on;
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking testbench for the pll clock select control
`timescale 1ns/10ps
`default_nettype none
`include "pcs_defs.svh"
module tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [`PCS_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, rs;
  logic stop_mode, break_state, break_clear_enable, xtal_run, lock_req;
  logic crystal_clock, vco_clock, pll_locked, pll_tracking;
  logic base_clock_out, crystal_clock_out, pll_irq_request;
  logic [7:0] rd, v;
  logic [3:0] wstrb;
  pcs_pkg::pcs_ana_out_s ana_out;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 32'h4c3a;
  initial begin
    aclk = 1'b0;
    forever #50 aclk = !aclk;
  end
  pcs_top i_pcs_top (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
    .rdata, .rresp, .crystal_clock, .vco_clock, .pll_locked, .pll_tracking,
    .stop_mode, .break_state, .break_clear_enable, .ana_out, .base_clock_out,
    .crystal_clock_out, .pll_irq_request);
  pcs_ana_model i_pcs_ana_model (.aclk, .xtal_run, .lock_req,
    .ana_in(ana_out), .crystal_clock, .vco_clock, .pll_locked, .pll_tracking);
  // -------
  // helpers
  // -------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] mul_seen(input logic [7:0] p);
    return (p[7:4] == 4'h0) ? 8'h01 : {4'h0, p[7:4]};
  endfunction
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    logic ka, kw, kr;
    int n;
    @(posedge aclk);
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    awaddr <= a;
    araddr <= a;
    wdata <= {24'h0, d};
    kr = 1'b0;
    for (n = 0; n < 60 && !kr; n++) begin
      @(negedge aclk);
      ka = w ? awready : arready;
      kw = wready;
      kr = w ? bvalid : rvalid;
      rd = rdata[7:0];
      rs = w ? bresp : rresp;
      @(posedge aclk);
      if (ka) awvalid <= 1'b0;
      if (ka) arvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (!kr) begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  task automatic wirq(input logic lv);
    int n;
    for (n = 0; n < 40 && pll_irq_request !== lv; n++) @(negedge aclk);
    chk({7'h0, pll_irq_request}, {7'h0, lv});
    if (pll_irq_request !== lv) wrap_up();
    @(posedge aclk);
  endtask
  task automatic cnt(input int exp);
    int t;
    logic p;
    t = 0;
    p = base_clock_out;
    repeat (40) begin
      @(negedge aclk);
      if (base_clock_out !== p) t++;
      p = base_clock_out;
    end
    n_checks++;
    if (t < exp - 1 || t > exp + 1) begin
      bad_count++;
      $display("wrong value at %0t: %0d base toggles", $time, t);
    end
  endtask
  // --------
  // sequence
  // --------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {stop_mode, break_state, break_clear_enable, lock_req} = 4'h0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    xtal_run = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`PCS_OFF_CTRL, 8'h2F);
    rc(`PCS_OFF_BWC, 8'h00);
    rc(`PCS_OFF_PROG, 8'h66);
    bus(1'b0, 4'hC, 8'h00);
    chk({6'h0, rs}, {6'h0, `PCS_RESP_SLVERR});
    v = 8'($random(seed));
    wr(`PCS_OFF_PROG, v);
    rc(`PCS_OFF_PROG, 8'h66);
    wr(`PCS_OFF_CTRL, 8'hA0);
    rc(`PCS_OFF_CTRL, 8'h2F);
    wr(`PCS_OFF_BWC, 8'h20);
    rc(`PCS_OFF_BWC, 8'h20);
    $display("register reset and access test done");
    wr(`PCS_OFF_BWC, 8'hA0);
    wr(`PCS_OFF_CTRL, 8'hA0);
    lock_req <= 1'b1;
    wirq(1'b1);
    rc(`PCS_OFF_CTRL, 8'hEF);
    rc(`PCS_OFF_CTRL, 8'hAF);
    wirq(1'b0);
    rc(`PCS_OFF_BWC, 8'hE0);
    lock_req <= 1'b0;
    wirq(1'b1);
    break_state <= 1'b1;
    rc(`PCS_OFF_CTRL, 8'hEF);
    rc(`PCS_OFF_CTRL, 8'hEF);
    break_clear_enable <= 1'b1;
    rc(`PCS_OFF_CTRL, 8'hEF);
    rc(`PCS_OFF_CTRL, 8'hAF);
    break_state <= 1'b0;
    wr(`PCS_OFF_BWC, 8'h00);
    rc(`PCS_OFF_BWC, 8'h20);
    lock_req <= 1'b1;
    repeat (8) @(posedge aclk);
    rc(`PCS_OFF_CTRL, 8'h2F);
    $display("lock flag test done");
    wr(`PCS_OFF_CTRL, 8'h30);
    rc(`PCS_OFF_CTRL, 8'h3F);
    wr(`PCS_OFF_CTRL, 8'h10);
    rc(`PCS_OFF_CTRL, 8'h3F);
    repeat (24) @(posedge aclk);
    cnt(10);
    xtal_run <= 1'b0;
    wr(`PCS_OFF_BWC, 8'h30);
    repeat (24) @(posedge aclk);
    rc(`PCS_OFF_BWC, 8'h30);
    xtal_run <= 1'b1;
    wr(`PCS_OFF_BWC, 8'h30);
    repeat (24) @(posedge aclk);
    rc(`PCS_OFF_BWC, 8'h20);
    stop_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    stop_mode <= 1'b0;
    rc(`PCS_OFF_CTRL, 8'h2F);
    rc(`PCS_OFF_BWC, 8'h20);
    $display("clock select test done");
    wr(`PCS_OFF_CTRL, 8'h00);
    rc(`PCS_OFF_CTRL, 8'h0F);
    wr(`PCS_OFF_CTRL, 8'h30);
    rc(`PCS_OFF_CTRL, 8'h2F);
    wr(`PCS_OFF_CTRL, 8'h00);
    wr(`PCS_OFF_BWC, 8'h00);
    repeat (4) begin
      v = 8'($random(seed));
      wr(`PCS_OFF_PROG, v);
      chk({4'h0, ana_out.multiplier}, mul_seen(v));
      rc(`PCS_OFF_PROG, v);
    end
    wr(`PCS_OFF_PROG, 8'h00);
    chk({4'h0, ana_out.multiplier}, 8'h01);
    wstrb <= 4'h0;
    wr(`PCS_OFF_PROG, 8'h55);
    wstrb <= 4'hF;
    rc(`PCS_OFF_PROG, 8'h00);
    wr(`PCS_OFF_CTRL, 8'h20);
    rc(`PCS_OFF_CTRL, 8'h0F);
    $display("programming test done");
    wrap_up();
  end
endmodule
`default_nettype wire
